// >>> bvsup_top.v
// bus voltage supervisor top: wishbone registers, run-time counter,
// bus voltage state machine, front end and crowbar control
// assumes a free-running converter and storage that answers at power-up
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "bvsup_defines.vh"
module bvsup_top #(
   parameter MS_CYCLES = `BVS_MS_CYCLES,
   parameter SAVE_SECONDS = `BVS_SAVE_S,
   parameter [9:0] HYST = `BVS_HYST_RST
) (
   input wire core_clk,
   input wire reset,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [9:0] bus_voltage_sense,
   input wire bus_voltage_valid,
   input wire [31:0] nv_count_in,
   input wire nv_count_valid,
   output reg nv_save_req,
   output reg [31:0] nv_save_data,
   input wire [3:0] group_ok_in,
   output wire [3:0] group_ok_out,
   output wire [3:0] group_ok_oe,
   input wire [3:0] group_error,
   output wire [3:0] aux_off,
   output reg front_end_enable,
   output reg crowbar_trigger,
   output wire ref_external,
   output reg program_req,
   input wire program_done,
   input wire [31:0] program_ok_set,
   output reg turn_on_req
);
   // normal state and the undervoltage path
   localparam S_NORM = 4'h0;
   localparam S_UVDLY = 4'h1;
   localparam S_UV = 4'h2;

   // overvoltage path
   localparam S_OVDLY = 4'h3;
   localparam S_OV1 = 4'h4;
   localparam S_OV2 = 4'h5;
   localparam S_CB = 4'h6;
   localparam S_OVHOLD = 4'h7;
   localparam S_OVREC = 4'h8;

   // reprogramming, shared by both paths
   localparam S_PROG = 4'h9;
   localparam S_WAITON = 4'hA;

   // configuration, status and counters
   reg [2:0] ctrl_q;
   reg [9:0] uv_q;
   reg [9:0] ov_q;
   reg [31:0] prop_q;
   reg [19:0] aux_q;
   reg low_q;
   reg high_q;
   reg [9:0] intermediate_bus_voltage_q;
   reg [31:0] rt_q;
   reg [31:0] pstat_q;
   reg [31:0] ms_cnt_q;
   reg [9:0] sec_ms_q;
   reg [31:0] save_cnt_q;
   reg [3:0] st_q;
   reg [3:0] st_d;
   reg [10:0] tmr_q;
   reg [10:0] ecb_q;
   reg ecb_on_q;
   reg err_kill_d1_q;
   reg boot_q;
   reg [31:0] rd_d;

   // propagation outputs
   wire [3:0] pull;
   wire err_kill;

   // bus access
   wire wb_req = wb_cyc_i & wb_stb_i;
   wire wr = wb_req & wb_we_i & wb_ack_o;
   wire [31:0] wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] wd = wb_dat_i & wm;
   wire wr_ctrl = wr && wb_adr_i == `BVS_ADR_CTRL;
   wire turn_on_cmd = wr_ctrl & wd[`BVS_CTRL_TURN_ON];
   wire fe_on_cmd = wr_ctrl & wd[`BVS_CTRL_FE_ON];
   wire stat_w1c = wr && wb_adr_i == `BVS_ADR_STAT;

   // time base
   wire ms_tick = ms_cnt_q == MS_CYCLES - 1;
   wire sec_tick = ms_tick && sec_ms_q == `BVS_SEC_MS;
   wire save_due = sec_tick && save_cnt_q == SAVE_SECONDS - 1;

   // threshold compares with symmetric hysteresis
   wire [10:0] v_ext = {1'b0, intermediate_bus_voltage_q};
   wire [10:0] v_plus = v_ext + {1'b0, HYST};
   wire uv_low = v_plus < {1'b0, uv_q};
   wire uv_ok = v_ext > ({1'b0, uv_q} + {1'b0, HYST});
   wire ov_hi = v_ext > ({1'b0, ov_q} + {1'b0, HYST});
   wire ov_ok = v_plus < {1'b0, ov_q};

   // state entry events
   wire chg = st_d != st_q;
   wire ent_uv = chg && st_d == S_UV;
   wire ent_ov1 = chg && st_d == S_OV1 && st_q == S_OVDLY;
   wire ent_ov2 = chg && st_d == S_OV2;
   wire ent_prog = chg && st_d == S_PROG;
   wire ent_norm = chg && st_d == S_NORM && (st_q == S_PROG || st_q == S_WAITON);
   // lines stay low until the converters are turned on again
   wire force_all = st_q != S_NORM && st_q != S_UVDLY && st_q != S_OVDLY;

   assign group_ok_out = 4'h0;
   assign group_ok_oe = pull;
   assign ref_external = ctrl_q[`BVS_CTRL_REF_EXT];

   bvsup_prop #(
      .NGRP(4)
   ) u_prop (
      .core_clk(core_clk),
      .reset(reset),
      .ok_in(group_ok_in),
      .err_in(group_error),
      .fault_en(prop_q[15:0]),
      .err_en(prop_q[31:16]),
      .force_all(force_all),
      .aux_en(aux_q[3:0]),
      .aux_grp(aux_q[11:4]),
      .err_front_end_enable(aux_q[19:16]),
      .pull_q(pull),
      .aux_off_q(aux_off),
      .err_kill_q(err_kill)
   );

   // bus voltage sequence
   always @* begin
      st_d = st_q;
      case (st_q)
         S_NORM: begin
            if (ov_hi)
               st_d = S_OVDLY;
            else if (uv_low)
               st_d = S_UVDLY;
         end
         S_UVDLY: begin
            if (!uv_low)
               st_d = S_NORM;
            else if (tmr_q >= `BVS_TRIP_MS)
               st_d = S_UV;
         end
         S_UV: begin
            if (uv_ok)
               st_d = S_PROG;
         end
         S_OVDLY: begin
            if (!ov_hi)
               st_d = S_NORM;
            else if (tmr_q >= `BVS_TRIP_MS)
               st_d = S_OV1;
         end
         S_OV1: begin
            if (ov_ok)
               st_d = S_OVREC;
            else if (tmr_q >= `BVS_OV_FE_MS)
               st_d = S_OV2;
         end
         S_OV2: begin
            if (ov_ok)
               st_d = S_OVREC;
            else if (tmr_q >= `BVS_OV_CB_MS)
               st_d = S_CB;
         end
         S_CB: begin
            if (tmr_q >= `BVS_CB_MS)
               st_d = S_OVHOLD;
         end
         S_OVHOLD: begin
            if (ov_ok)
               st_d = S_OVREC;
         end
         S_OVREC: begin
            if (!ov_ok)
               st_d = S_OVHOLD;
            else if (tmr_q >= `BVS_REC_MS)
               st_d = S_PROG;
         end
         S_PROG: begin
            if (program_done)
               st_d = ctrl_q[`BVS_CTRL_AUTO_ON] ? S_NORM : S_WAITON;
         end
         S_WAITON: begin
            if (turn_on_cmd)
               st_d = S_NORM;
         end
         default: st_d = S_NORM;
      endcase
   end

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_q <= S_NORM;
         tmr_q <= 11'h000;
      end else begin
         st_q <= st_d;
         if (chg)
            tmr_q <= 11'h000;
         else if (ms_tick && tmr_q != 11'h7FF)
            tmr_q <= tmr_q + 11'h001;
      end
   end

   // time base and run-time counter
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ms_cnt_q <= 32'h00000000;
         sec_ms_q <= 10'h000;
         save_cnt_q <= 32'h00000000;
         rt_q <= 32'h00000000;
      end else begin
         ms_cnt_q <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
         if (ms_tick)
            sec_ms_q <= sec_tick ? 10'h000 : sec_ms_q + 10'h001;
         if (sec_tick)
            save_cnt_q <= save_due ? 32'h00000000 : save_cnt_q + 32'h00000001;
         if (nv_count_valid)
            rt_q <= nv_count_in;
         else if (sec_tick)
            rt_q <= rt_q + 32'h00000001;
      end
   end

   // counter save, sample latch, programming status
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         nv_save_req <= 1'b0;
         nv_save_data <= 32'h00000000;
         intermediate_bus_voltage_q <= 10'h000;
         pstat_q <= 32'h00000000;
      end else begin
         nv_save_req <= save_due | ent_uv | ent_ov1;
         if (save_due | ent_uv | ent_ov1)
            nv_save_data <= rt_q;
         if (bus_voltage_valid)
            intermediate_bus_voltage_q <= bus_voltage_sense;
         // a status set in the clearing cycle survives
         pstat_q <= ((ent_uv | ent_ov2) ? 32'h00000000 : pstat_q) | program_ok_set;
      end
   end

   // front end, crowbar and converter requests
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         boot_q <= 1'b1;
         front_end_enable <= 1'b0;
         crowbar_trigger <= 1'b0;
         ecb_on_q <= 1'b0;
         ecb_q <= 11'h000;
         err_kill_d1_q <= 1'b0;
         program_req <= 1'b0;
         turn_on_req <= 1'b0;
      end else begin
         boot_q <= 1'b0;
         err_kill_d1_q <= err_kill;
         if (err_kill | ent_ov2)
            front_end_enable <= 1'b0;
         else if ((boot_q & ctrl_q[`BVS_CTRL_FE_AUTO]) | fe_on_cmd)
            front_end_enable <= 1'b1;
         else if (ent_prog && st_q == S_OVREC)
            front_end_enable <= 1'b1;
         // error crowbar pulse ends on the next millisecond tick
         if (err_kill & ~err_kill_d1_q) begin
            ecb_on_q <= 1'b1;
            ecb_q <= 11'h000;
         end else if (ecb_on_q && ms_tick) begin
            if (ecb_q + 11'h001 >= `BVS_CB_MS)
               ecb_on_q <= 1'b0;
            ecb_q <= ecb_q + 11'h001;
         end
         crowbar_trigger <= st_d == S_CB || ecb_on_q;
         program_req <= ent_prog;
         turn_on_req <= ent_norm;
      end
   end

   // registers and flags
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl_q <= `BVS_CTRL_RST;
         uv_q <= `BVS_UV_RST;
         ov_q <= `BVS_OV_RST;
         prop_q <= `BVS_PROP_RST;
         aux_q <= `BVS_AUX_RST;
         low_q <= 1'b0;
         high_q <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl_q <= (ctrl_q & ~wm[2:0]) | wd[2:0];
         if (wr && wb_adr_i == `BVS_ADR_UV)
            uv_q <= (uv_q & ~wm[9:0]) | wd[9:0];
         if (wr && wb_adr_i == `BVS_ADR_OV)
            ov_q <= (ov_q & ~wm[9:0]) | wd[9:0];
         if (wr && wb_adr_i == `BVS_ADR_PROP)
            prop_q <= (prop_q & ~wm) | wd;
         if (wr && wb_adr_i == `BVS_ADR_AUX)
            aux_q <= (aux_q & ~wm[19:0]) | wd[19:0];
         // hardware set wins over a write-one clear
         low_q <= ent_uv | (low_q & ~(stat_w1c & wd[`BVS_STAT_LOW]));
         high_q <= ent_ov2 | (high_q & ~(stat_w1c & wd[`BVS_STAT_HIGH]));
      end
   end

   // read data, loaded into the output register at the take edge
   always @* begin
      rd_d = 32'h00000000;
      case (wb_adr_i)
         `BVS_ADR_CTRL: rd_d = {29'h00000000, ctrl_q};
         `BVS_ADR_UV: rd_d = {22'h000000, uv_q};
         `BVS_ADR_OV: rd_d = {22'h000000, ov_q};
         `BVS_ADR_STAT: rd_d = {24'h000000, st_q, crowbar_trigger, front_end_enable,
                                high_q, low_q};
         `BVS_ADR_VBUS: rd_d = {22'h000000, intermediate_bus_voltage_q};
         `BVS_ADR_RTC: rd_d = rt_q;
         `BVS_ADR_PSTAT: rd_d = pstat_q;
         `BVS_ADR_PROP: rd_d = prop_q;
         `BVS_ADR_AUX: rd_d = {12'h000, aux_q};
         default: rd_d = 32'h00000000;
      endcase
   end

   // one wait state, ack for one cycle, unmapped reads zero
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         if (wb_req & ~wb_ack_o)
            wb_dat_o <= rd_d;
      end
   end
endmodule // bvsup_top
`default_nettype wire

// >>> bvsup_defines.vh
// bus voltage supervisor: offsets, field positions, reset values, timing counts
// assumes a 100 MHz core clock and a classic wishbone slave port
// Operation
// - keep a 32-bit run-time counter that counts whole seconds while powered
// - load the count from storage at power-up, save it back periodically
// - latch every converter sample of the bus voltage for readback
// - compare samples with programmable under/over thresholds with symmetric hysteresis
// - below undervoltage minus hysteresis, pull all group fault lines low
// - undervoltage also clears programming status, saves counter, sets low flag
// - above undervoltage plus hysteresis, reprogram; auto turn-on or await command
// - above overvoltage plus hysteresis, pull all lines low and save counter
// - overvoltage held 50 ms: drop front-end enable, clear status, set high flag
// - overvoltage held further 50 ms: one 1 ms crowbar pulse
// - one second after overvoltage clears: front-end on, reprogram, maybe turn on
// - about 1 ms from threshold crossing to pulling the fault lines
// - configuration bit selects internal or external 2.5 V reference
// - four groups A to D, each of 1 to 32 converters
// - per-group propagation enables; errors also act on front end and crowbar
// - group propagation completes well under 10 us
// - per-device aux fault enable; never from aux devices back to converters
// - option to assert front-end enable at power-up, else bus command or overvoltage recovery only
// - a converter-pulled group line pulls other lines as programmed
`ifndef BVSUP_DEFINES_VH
`define BVSUP_DEFINES_VH

`define BVS_ADR_CTRL 8'h00
`define BVS_ADR_UV 8'h04
`define BVS_ADR_OV 8'h08
`define BVS_ADR_STAT 8'h0C
`define BVS_ADR_VBUS 8'h10
`define BVS_ADR_RTC 8'h14
`define BVS_ADR_PSTAT 8'h18
`define BVS_ADR_PROP 8'h1C
`define BVS_ADR_AUX 8'h20

`define BVS_CTRL_AUTO_ON 0
`define BVS_CTRL_FE_AUTO 1
`define BVS_CTRL_REF_EXT 2
`define BVS_CTRL_TURN_ON 3
`define BVS_CTRL_FE_ON 4
`define BVS_STAT_LOW 0
`define BVS_STAT_HIGH 1

`define BVS_CTRL_RST 3'h3
`define BVS_UV_RST 10'h2E8
`define BVS_OV_RST 10'h380
`define BVS_HYST_RST 10'h004
`define BVS_PROP_RST 32'h00000000
`define BVS_AUX_RST 20'h00000

`define BVS_CLK_NS 10
`define BVS_MS_NS 1000000
`define BVS_MS_CYCLES (`BVS_MS_NS / `BVS_CLK_NS)
`define BVS_SAVE_S 60
`define BVS_TRIP_MS 11'h001
`define BVS_OV_FE_MS 11'h032
`define BVS_OV_CB_MS 11'h032
`define BVS_CB_MS 11'h001
`define BVS_REC_MS 11'h3E8
`define BVS_SEC_MS 10'h3E7

`endif

// >>> bvsup_prop.v
// bus voltage supervisor: group fault and error propagation matrix
// assumes active-low open-drain group lines, sampled synchronously
`timescale 1ns/1ns
`default_nettype none
module bvsup_prop #(
   parameter NGRP = 4
) (
   input wire core_clk,
   input wire reset,
   input wire [NGRP-1:0] ok_in,
   input wire [NGRP-1:0] err_in,
   input wire [NGRP*NGRP-1:0] fault_en,
   input wire [NGRP*NGRP-1:0] err_en,
   input wire force_all,
   input wire [NGRP-1:0] aux_en,
   input wire [2*NGRP-1:0] aux_grp,
   input wire [NGRP-1:0] err_front_end_enable,
   output reg [NGRP-1:0] pull_q,
   output reg [NGRP-1:0] aux_off_q,
   output reg err_kill_q
);
   wire [NGRP*NGRP-1:0] hit;
   wire [NGRP-1:0] pull_d;
   wire [NGRP-1:0] aux_d;
   genvar g, s;
   generate
      for (g = 0; g < NGRP; g = g + 1) begin : grp
         for (s = 0; s < NGRP; s = s + 1) begin : src
            // a source never re-pulls itself
            assign hit[g*NGRP+s] = (s != g) &&
               ((~ok_in[s] & fault_en[s*NGRP+g]) | (err_in[s] & err_en[s*NGRP+g]));
         end
         assign pull_d[g] = force_all | (|hit[g*NGRP+NGRP-1:g*NGRP]);
         // aux devices only receive, they have no path back
         assign aux_d[g] = aux_en[g] & ~ok_in[aux_grp[2*g+1:2*g]];
      end
   endgenerate
   // one cycle from line to line, far below the limit
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pull_q <= {NGRP{1'b0}};
         aux_off_q <= {NGRP{1'b0}};
         err_kill_q <= 1'b0;
      end else begin
         pull_q <= pull_d;
         aux_off_q <= aux_d;
         err_kill_q <= |(err_in & err_front_end_enable);
      end
   end
endmodule // bvsup_prop
`default_nettype wire

// >>> bvsup_monitor.sv
// bus voltage supervisor checker: timing relations seen at the top ports
// assumes it is bound into bvsup_top and shares its millisecond parameter
`timescale 1ns/1ns
`default_nettype none
module bvsup_monitor #(
   parameter MS_CYCLES = 10
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic wb_ack_o,
   input wire logic nv_save_req,
   input wire logic [31:0] nv_save_data,
   input wire logic [3:0] group_ok_oe,
   input wire logic front_end_enable,
   input wire logic crowbar_trigger,
   input wire logic ref_external,
   input wire logic program_req,
   input wire logic turn_on_req
);
   logic [15:0] cb_cnt_q;
   // length of the crowbar pulse so far
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cb_cnt_q <= 16'h0000;
      end else begin
         cb_cnt_q <= crowbar_trigger ? cb_cnt_q + 16'h0001 : 16'h0000;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   property p_ok_low; program_req |-> group_ok_oe == 4'hF; endproperty
   a_ok_low: assert property (p_ok_low)
      else $error("group lines released before reprogramming");
   property p_cb_len; crowbar_trigger |-> cb_cnt_q <= MS_CYCLES; endproperty
   a_cb_len: assert property (p_cb_len)
      else $error("crowbar pulse too long");
   property p_cb_fe; $rose(crowbar_trigger) |-> ##[0:2] !front_end_enable; endproperty
   a_cb_fe: assert property (p_cb_fe)
      else $error("crowbar fired with front end on");
   property p_prog; program_req |=> !program_req; endproperty
   a_prog: assert property (p_prog)
      else $error("program request not a pulse");
   property p_turn; turn_on_req |=> !turn_on_req; endproperty
   a_turn: assert property (p_turn)
      else $error("turn-on request not a pulse");
   property p_save; nv_save_req |=> !nv_save_req; endproperty
   a_save: assert property (p_save)
      else $error("save request not a pulse");
   property p_ref;
      !(wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00)
         |=> $stable(ref_external);
   endproperty
   a_ref: assert property (p_ref)
      else $error("reference select changed without a write");
   property p_data; !nv_save_req |-> $stable(nv_save_data); endproperty
   a_data: assert property (p_data)
      else $error("saved count changed without a save");
   c_cb: cover property ($rose(crowbar_trigger));
   c_turn: cover property (turn_on_req);
   c_save: cover property (nv_save_req);
endmodule // bvsup_monitor
bind bvsup_top bvsup_monitor #(.MS_CYCLES(MS_CYCLES)) i_mon (.core_clk, .reset, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .nv_save_req, .nv_save_data, .group_ok_oe,
   .front_end_enable, .crowbar_trigger, .ref_external, .program_req, .turn_on_req);
`default_nettype wire

// >>> bvsup_pol_model.sv
// converter model: pulled-up open-drain group lines, programming replies
// assumes one-cycle program and turn-on pulses from the supervisor
`timescale 1ns/1ns
`default_nettype none
module bvsup_pol_model (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic program_req,
   input wire logic turn_on_req,
   input wire logic [3:0] group_ok_oe,
   input wire logic [3:0] fault_pull,
   output logic [3:0] group_ok_in,
   output logic program_done,
   output logic [31:0] program_ok_set,
   output logic powered
);
   logic [2:0] wait_q;
   logic [3:0] line_q;
   // wired-and of all pullers, high when released
   assign group_ok_in = ~(group_ok_oe | fault_pull);
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wait_q <= 3'h0;
         line_q <= 4'hF;
         program_done <= 1'b0;
         program_ok_set <= 32'h00000000;
         powered <= 1'b0;
      end else begin
         line_q <= group_ok_in;
         program_done <= wait_q == 3'h1;
         program_ok_set <= {28'h0000000, {4{wait_q == 3'h1}}};
         if (program_req) wait_q <= 3'h6;
         else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
         // a falling line turns the converters off
         if (turn_on_req) powered <= 1'b1;
         else if (|(line_q & ~group_ok_in)) powered <= 1'b0;
      end
   end
endmodule // bvsup_pol_model
`default_nettype wire

// >>> bus_voltage_supervisor_tb.sv
// bench: wishbone master, sample source, storage and converter model
// assumes a 10-cycle millisecond and a 2 s save period in the design
`timescale 1ns/1ns
`default_nettype none
module bus_voltage_supervisor_tb;
   logic core_clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF, group_error = 4'h0, fpull = 4'h0;
   logic [3:0] group_ok_in, group_ok_out, group_ok_oe, aux_off;
   logic [31:0] wb_dat_i = 32'h0, nv_count_in = 32'h0, wb_dat_o, nv_save_data, rd, t;
   logic [31:0] program_ok_set;
   logic [9:0] bus_voltage_sense = 10'h320;
   logic bus_voltage_valid = 1'b0, nv_count_valid = 1'b0, wb_ack_o, nv_save_req, pwr;
   logic front_end_enable, crowbar_trigger, ref_external, program_req, program_done;
   logic turn_on_req;
   integer fails = 0, check_count = 0, n, tp, n_save = 0, n_prog = 0, n_turn = 0, wd = 0;
   always #5 core_clk = ~core_clk;
   bvsup_top #(.MS_CYCLES(10), .SAVE_SECONDS(2)) i_dut (.core_clk, .reset, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .bus_voltage_sense, .bus_voltage_valid, .nv_count_in, .nv_count_valid, .nv_save_req,
      .nv_save_data, .group_ok_in, .group_ok_out, .group_ok_oe, .group_error, .aux_off,
      .front_end_enable, .crowbar_trigger, .ref_external, .program_req, .program_done,
      .program_ok_set, .turn_on_req);
   bvsup_pol_model i_pol (.core_clk, .reset, .program_req, .turn_on_req, .group_ok_oe,
      .fault_pull(fpull), .group_ok_in, .program_done, .program_ok_set, .powered(pwr));
   task stop_test;
      if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input integer k);
      repeat (k) @(posedge core_clk);
   endtask
   task wbx(input [7:0] a, input w, input [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1) @(posedge core_clk);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask
   // samples, pulse counters and the hang limit
   always @(posedge core_clk) begin
      bus_voltage_valid <= ~bus_voltage_valid;
      n_save <= n_save + nv_save_req;
      n_prog <= n_prog + program_req;
      n_turn <= n_turn + turn_on_req;
      wd <= wd + 1;
      if (wd == 60000) begin
         fails = fails + 1;
         stop_test();
      end
   end
   task t_defaults;
      wbx(8'h00, 1'b0, 0);
      chk(rd, 32'h00000003);
      wbx(8'h04, 1'b0, 0);
      chk(rd, 32'h000002E8);
      wbx(8'h10, 1'b0, 0);
      chk(rd, 32'h00000320);
      wbx(8'h24, 1'b1, 32'hFFFFFFFF);
      wbx(8'h24, 1'b0, 0);
      chk(rd, 32'h00000000);
      chk(front_end_enable, 1'b1);
   endtask
   task t_uv;
      t = n_save;
      tp = n_prog;
      bus_voltage_sense <= 10'h2E0;
      n = 0;
      while (group_ok_oe !== 4'hF) begin
         @(posedge core_clk);
         n = n + 1;
      end
      cyc(2);
      chk(n <= 25, 1);
      chk(group_ok_out, 4'h0);
      chk(n_save - t, 1);
      wbx(8'h0C, 1'b0, 0);
      chk(rd[0], 1);
      bus_voltage_sense <= 10'h2F0;
      while (pwr !== 1'b1) @(posedge core_clk);
      cyc(2);
      chk(n_prog - tp, 1);
      chk(group_ok_oe, 0);
      wbx(8'h18, 1'b0, 0);
      chk(rd, 32'h0000000F);
      wbx(8'h0C, 1'b1, 32'h1);
      wbx(8'h0C, 1'b0, 0);
      chk(rd[0], 0);
   endtask
   task t_ov;
      wbx(8'h00, 1'b1, 32'h2);
      t = n_save;
      bus_voltage_sense <= 10'h390;
      while (group_ok_oe !== 4'hF) @(posedge core_clk);
      n = 0;
      while (front_end_enable !== 1'b0) begin
         @(posedge core_clk);
         n = n + 1;
      end
      chk(n >= 480 && n <= 510, 1);
      chk(n_save - t, 1);
      n = 0;
      while (crowbar_trigger !== 1'b1) begin
         @(posedge core_clk);
         n = n + 1;
      end
      chk(n >= 480 && n <= 510, 1);
      n = 0;
      while (crowbar_trigger !== 1'b0) begin
         @(posedge core_clk);
         n = n + 1;
      end
      chk(n >= 8 && n <= 11, 1);
      wbx(8'h0C, 1'b0, 0);
      chk(rd[1], 1);
      wbx(8'h18, 1'b0, 0);
      chk(rd, 0);
      bus_voltage_sense <= 10'h320;
      n = 0;
      while (front_end_enable !== 1'b1) begin
         @(posedge core_clk);
         n = n + 1;
      end
      chk(n >= 9960 && n <= 10030, 1);
      t = n_turn;
      cyc(40);
      chk(n_turn - t, 0);
      wbx(8'h00, 1'b1, 32'hA);
      cyc(3);
      chk(n_turn - t, 1);
      chk(pwr, 1);
   endtask
   task t_prop;
      wbx(8'h1C, 1'b1, 32'h4);
      wbx(8'h20, 1'b1, 32'h1);
      fpull <= 4'h1;
      cyc(4);
      chk(group_ok_oe, 4'h4);
      chk(aux_off, 4'h1);
      fpull <= 4'h0;
      cyc(4);
      chk(group_ok_oe, 0);
      wbx(8'h20, 1'b1, 0);
      fpull <= 4'h1;
      cyc(4);
      chk(aux_off, 0);
      fpull <= 4'h0;
   endtask
   task t_err;
      wbx(8'h1C, 1'b1, 32'h00020000);
      wbx(8'h20, 1'b1, 32'h00010000);
      group_error <= 4'h1;
      cyc(4);
      chk(group_ok_oe, 4'h2);
      chk(front_end_enable, 0);
      chk(crowbar_trigger, 1);
      group_error <= 4'h0;
      cyc(20);
      chk(crowbar_trigger, 0);
      chk(group_ok_oe, 4'h0);
      wbx(8'h00, 1'b1, 32'h12);
      cyc(3);
      chk(front_end_enable, 1);
   endtask
   task t_ref;
      wbx(8'h00, 1'b1, 32'h7);
      chk(ref_external, 1);
      reset <= 1'b1;
      cyc(2);
      reset <= 1'b0;
      cyc(3);
      chk(ref_external, 0);
      chk(front_end_enable, 1);
   endtask
   task t_rtc;
      nv_count_in <= 32'h00001000;
      nv_count_valid <= 1'b1;
      cyc(1);
      nv_count_valid <= 1'b0;
      wbx(8'h14, 1'b0, 0);
      t = rd;
      chk(t - 32'h1000 <= 1, 1);
      cyc(9995);
      wbx(8'h14, 1'b0, 0);
      chk(rd - t, 1);
      tp = n_save;
      while (n_save == tp) @(posedge core_clk);
      wbx(8'h14, 1'b0, 0);
      // the save takes the count as it stood before the second tick
      chk(rd - t, 2);
      chk(nv_save_data, t + 32'h00000001);
   endtask
   initial begin
      cyc(6);
      reset <= 1'b0;
      cyc(1);
      t_defaults();
      t_uv();
      t_ov();
      t_prop();
      t_err();
      t_ref();
      t_rtc();
      stop_test();
   end
endmodule // bus_voltage_supervisor_tb
`default_nettype wire
